// ==== logic/wdse_cfg.svh ====
`ifndef WDSE_CFG_SVH
`define WDSE_CFG_SVH

// bit positions inside the watchdog control word
`define WDSE_BIT_UNLOCK 0
`define WDSE_BIT_ARM    1
`define WDSE_BIT_FLAG   2
`define WDSE_BIT_ACTION 3
`define WDSE_PRE_LSB    4
`define WDSE_PRE_MSB    7

// reset values of the control fields
`define WDSE_ARM_RST    1'b0
`define WDSE_FLAG_RST   1'b0
`define WDSE_ACTION_RST 1'b0
`define WDSE_PRE_RST    4'h9

// largest prescaler code that scales the period, larger codes clamp to it
`define WDSE_PRE_MAX    4'h9

// shortest timeout, in base ticks, for prescaler code zero
`define WDSE_PERIOD_BASE 14'h0010

// clock period and base tick period, in ns
`define WDSE_CLK_NS     40
`define WDSE_TICK_NS    1000
// base tick in clock cycles, rounded up
`define WDSE_TICK_CYC   ((`WDSE_TICK_NS + `WDSE_CLK_NS - 1) / `WDSE_CLK_NS)

// count loaded by an unlock step; the window for the following control write stays open this many cycles plus one
`define WDSE_UNLOCK_CYC 4'h8

`endif

// ==== logic/wdse_pkg.sv ====
`default_nettype none

package wdse_pkg;

  // control word as software writes it, msb first
  typedef struct packed {
    logic [3:0] prescale;              // timeout period select
    logic       timeout_action_select; // 1: interrupt, 0: reset
    logic       timeout_flag;          // written 0 clears the flag
    logic       watchdog_arm;          // written 1 re-arms and clears counters
    logic       control_write_unlock;  // first step of the write sequence
  } wdse_ctrl_type;

  // status as seen by software
  typedef struct packed {
    logic [3:0] prescale;
    logic       timeout_action_select;
    logic       timeout_flag;
    logic       watchdog_arm;
    logic       unlock_open;
  } wdse_stat_type;

  // phase of the protected write sequence
  typedef enum logic [0:0] {
    WDSE_LOCKED = 1'b0,
    WDSE_OPEN   = 1'b1
  } wdse_phase_type;

  // whole state of the block
  typedef struct packed {
    wdse_phase_type phase;
    logic [3:0]     unlock_cnt;
    logic           watchdog_arm;
    logic           timeout_flag;
    logic           timeout_action_select;
    logic [3:0]     prescale;
    logic [4:0]     div_cnt;
    logic [13:0]    tick_cnt;
    logic           wd_reset;
    logic           wd_irq;
  } wdse_state_type;

endpackage
`default_nettype wire

// ==== logic/wdse_top.sv ====
// How it works
// [R1] interrupt action lets it run as interval timer
// [R2] prescaler code selects the timeout period
// [R3] timeout sets flag bit 2, written zero clears
// [R4] hardware reset clears flag, watchdog reset keeps
// [R5] setting arm enables and clears all counters
// [R6] software re-arms before each period ends
// [R7] missed re-arm gives reset or interrupt
// [R8] arm clears on zero write, reset, supply interrupt
// [R9] control write accepted only after unlock step
`include "wdse_cfg.svh"
`default_nettype none

module wdse_top
  import wdse_pkg::*;
(
  input  wire logic          clock_i,              // 25 MHz core clock
  input  wire logic          rstn_i,               // external hardware reset, active low
  input  wire logic          ctrl_wr_i,            // one-cycle write strobe of the control word
  input  wire wdse_ctrl_type ctrl_wdata_i,         // control word written with the strobe
  input  wire logic          supply_monitor_irq_i, // supply monitor interrupt pulse
  output logic               wd_reset_o,           // one-cycle system reset request
  output logic               wd_irq_o,             // one-cycle timeout interrupt
  output wdse_stat_type      status_o              // control and status readback
);

  // reset release synchroniser
  logic           rst_meta_ff;  // first stage, only read by the second
  logic           rst_sync_ff;  // released reset used by the block

  // block state and its next value
  wdse_state_type state_ff;
  wdse_state_type nxt_state;

  // base tick enable from the divider
  logic           tick;
  // period end seen this cycle
  logic           timeout;

  // last tick index of a period for a prescaler code
  function automatic logic [13:0] wdse_last_tick(input logic [3:0] pre);
    logic [3:0] p;
    // clamp keeps the shifted period inside the 14-bit tick counter
    p = (pre > `WDSE_PRE_MAX) ? `WDSE_PRE_MAX : pre;
    return (`WDSE_PERIOD_BASE << p) - 14'h0001;
  endfunction

  // the release is delayed two edges so that no flop sees a ragged deassert
  always_ff @(posedge clock_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // next state of the whole watchdog
  always_comb
  begin
    nxt_state          = state_ff;
    nxt_state.wd_reset = 1'b0;
    nxt_state.wd_irq   = 1'b0;
    tick               = 1'b0;
    timeout            = 1'b0;

    // base divider only runs while armed, so a disarmed watchdog is frozen
    if (state_ff.watchdog_arm)
    begin
      if (state_ff.div_cnt == 5'(`WDSE_TICK_CYC - 1))
      begin
        nxt_state.div_cnt = 5'h00;
        tick              = 1'b1;
      end
      else
      begin
        nxt_state.div_cnt = state_ff.div_cnt + 5'h01;
      end
    end
    else
    begin
      // idle divider stays at zero
      nxt_state.div_cnt = 5'h00;
    end

    // period counter in base ticks
    if (tick)
    begin
      if (state_ff.tick_cnt >= wdse_last_tick(state_ff.prescale)) // see [R2]
      begin
        // period ran out with no re-arm from software
        nxt_state.tick_cnt = 14'h0000;
        timeout            = 1'b1;
      end
      else
      begin
        nxt_state.tick_cnt = state_ff.tick_cnt + 14'h0001;
      end
    end

    // unlock step stays open for a short window only
    if (state_ff.phase == WDSE_OPEN)
    begin
      if (state_ff.unlock_cnt == 4'h0)
      begin
        nxt_state.phase = WDSE_LOCKED;
      end
      else
      begin
        nxt_state.unlock_cnt = state_ff.unlock_cnt - 4'h1;
      end
    end

    // control write from software
    if (ctrl_wr_i)
    begin
      if (state_ff.phase == WDSE_OPEN)
      begin
        // second step of the sequence: the word is taken
        nxt_state.phase                 = WDSE_LOCKED; // see [R9]
        nxt_state.unlock_cnt            = 4'h0;
        nxt_state.prescale              = ctrl_wdata_i.prescale;
        nxt_state.timeout_action_select = ctrl_wdata_i.timeout_action_select;
        if (ctrl_wdata_i.watchdog_arm)
        begin
          // re-arm restarts the whole interval
          nxt_state.watchdog_arm = 1'b1; // see [R5]
          nxt_state.div_cnt      = 5'h00; // see [R5]
          nxt_state.tick_cnt     = 14'h0000; // see [R5]
        end
        else
        begin
          // software disarm
          nxt_state.watchdog_arm = 1'b0; // see [R8]
          nxt_state.div_cnt      = 5'h00;
          nxt_state.tick_cnt     = 14'h0000;
        end
        if (!ctrl_wdata_i.timeout_flag)
        begin
          // writing zero clears, writing one leaves the flag alone
          nxt_state.timeout_flag = 1'b0; // see [R3]
        end
      end
      else if (ctrl_wdata_i.control_write_unlock)
      begin
        // first step: open the window for the next write
        nxt_state.phase      = WDSE_OPEN; // see [R9]
        nxt_state.unlock_cnt = `WDSE_UNLOCK_CYC;
      end
      // any other write without the unlock step is dropped
      // so a stray store cannot disarm or retune a running watchdog
    end

    // timeout comes after the write so that its flag set beats a clear
    if (timeout)
    begin
      nxt_state.timeout_flag = 1'b1; // see [R3]
      if (state_ff.timeout_action_select)
      begin
        // interrupt action: stays armed and starts the next interval
        nxt_state.wd_irq = 1'b1; // see [R7] [R1]
      end
      else
      begin
        // reset action: the watchdog disarms itself
        nxt_state.wd_reset     = 1'b1; // see [R7]
        nxt_state.watchdog_arm = 1'b0; // see [R8]
        nxt_state.div_cnt      = 5'h00;
        nxt_state.tick_cnt     = 14'h0000;
      end
    end

    // supply trouble stops the watchdog, checked last so it always wins
    if (supply_monitor_irq_i)
    begin
      nxt_state.watchdog_arm = 1'b0; // see [R8]
      nxt_state.div_cnt      = 5'h00;
      nxt_state.tick_cnt     = 14'h0000;
    end
  end

  // state register; only the external reset clears it, so the flag
  // survives the system reset that the watchdog itself requests
  // the reset request leaves this block and never comes back in here
  always_ff @(posedge clock_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      state_ff.phase                 <= WDSE_LOCKED;
      state_ff.unlock_cnt            <= 4'h0;
      state_ff.watchdog_arm          <= `WDSE_ARM_RST; // see [R8]
      state_ff.timeout_flag          <= `WDSE_FLAG_RST; // see [R4]
      state_ff.timeout_action_select <= `WDSE_ACTION_RST;
      state_ff.prescale              <= `WDSE_PRE_RST;
      state_ff.div_cnt               <= 5'h00;
      state_ff.tick_cnt              <= 14'h0000;
      state_ff.wd_reset              <= 1'b0;
      state_ff.wd_irq                <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // outputs are wires straight off the state flops
  // unlock_open is a compare of one flop bit, so it cannot glitch either
  assign wd_reset_o                     = state_ff.wd_reset;
  assign wd_irq_o                       = state_ff.wd_irq;
  assign status_o.prescale              = state_ff.prescale;
  assign status_o.timeout_action_select = state_ff.timeout_action_select;
  assign status_o.timeout_flag          = state_ff.timeout_flag;
  assign status_o.watchdog_arm          = state_ff.watchdog_arm;
  assign status_o.unlock_open           = (state_ff.phase == WDSE_OPEN);

endmodule // wdse_top
`default_nettype wire

// ==== testbench/wdse_watch_properties.sv ====
`default_nettype none

module wdse_watch_properties
  import wdse_pkg::*;
(
  input wire logic          clock_i,
  input wire logic          rstn_i,
  input wire logic          ctrl_wr_i,
  input wire wdse_ctrl_type ctrl_wdata_i,
  input wire logic          supply_monitor_irq_i,
  input wire logic          wd_reset_o,
  input wire logic          wd_irq_o,
  input wire wdse_stat_type status_o
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);

  a_irq_sets_flag: assert property (wd_irq_o |-> status_o.timeout_flag)
    else $error("interrupt pulse without timeout flag");
  // the action is judged as it stood when the period ran out, a write
  // landing on the pulse edge may already have changed it
  a_irq_needs_sel: assert property (
    wd_irq_o |-> $past(status_o.timeout_action_select))
    else $error("interrupt pulse while reset action selected");
  // arm is checked with the pulse, software may re-arm on the next edge
  a_rst_clears_arm: assert property (
    wd_reset_o |-> status_o.timeout_flag && !status_o.watchdog_arm)
    else $error("watchdog reset left arm set or flag clear");
  a_pulse_single: assert property (wd_irq_o |=> !wd_irq_o)
    else $error("interrupt pulse longer than one cycle");
  // two idle cycles guard against the pulse that clears arm itself
  a_idle_quiet: assert property (
    !status_o.watchdog_arm [*2] |-> !wd_irq_o && !wd_reset_o)
    else $error("timeout pulse while disarmed");
  // flag only drops through an accepted write or hardware reset
  a_flag_sticky: assert property (
    status_o.timeout_flag && !ctrl_wr_i |=> status_o.timeout_flag)
    else $error("timeout flag dropped without a write");
  a_supply_disarm: assert property (
    supply_monitor_irq_i |=> !status_o.watchdog_arm)
    else $error("supply monitor interrupt left arm set");
  a_lone_dropped: assert property (
    ctrl_wr_i && !status_o.unlock_open && !ctrl_wdata_i.control_write_unlock
    |=> $stable(status_o[7:3]))
    else $error("control write taken without unlock");
  // a pulse already launched at the write edge may still show, then quiet
  a_rearm_restart: assert property (
    ctrl_wr_i && status_o.unlock_open && ctrl_wdata_i.watchdog_arm
    && !supply_monitor_irq_i |=> ##1 (!wd_irq_o && !wd_reset_o) [*8])
    else $error("timeout pulse right after re-arm");
endmodule // wdse_watch_properties

bind wdse_top wdse_watch_properties u_chk (
  .clock_i              (clock_i),
  .rstn_i               (rstn_i),
  .ctrl_wr_i            (ctrl_wr_i),
  .ctrl_wdata_i         (ctrl_wdata_i),
  .supply_monitor_irq_i (supply_monitor_irq_i),
  .wd_reset_o           (wd_reset_o),
  .wd_irq_o             (wd_irq_o),
  .status_o             (status_o)
);
`default_nettype wire

// ==== testbench/tb_top.sv ====
`default_nettype none

module tb_top
  import wdse_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic          clock_i = 1'b0;              // 25 MHz core clock
  logic          rstn_i = 1'b0;               // hardware reset, held at start
  logic          ctrl_wr_i = 1'b0;            // write strobe
  wdse_ctrl_type ctrl_wdata_i = '0;           // control word
  logic          supply_monitor_irq_i = 1'b0; // supply monitor interrupt
  wire logic     wd_reset_o;                  // reset request pulse
  wire logic     wd_irq_o;                    // timeout interrupt pulse
  wdse_stat_type status_o;                    // readback
  int            errors = 0;                  // mismatches
  int            n_tests = 0;                 // comparisons
  int            c;                           // cycles waited for a pulse

  wdse_top DUT (
    .clock_i              (clock_i),
    .rstn_i               (rstn_i),
    .ctrl_wr_i            (ctrl_wr_i),
    .ctrl_wdata_i         (ctrl_wdata_i),
    .supply_monitor_irq_i (supply_monitor_irq_i),
    .wd_reset_o           (wd_reset_o),
    .wd_irq_o             (wd_irq_o),
    .status_o             (status_o)
  );

  // free-running clock, 40 ns period
  initial forever #20 clock_i = ~clock_i;

  // summary and verdict, the only way out of the run
  task end_of_test();
    $display("errors %0d compares %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // compare one value against its expectation
  task check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single write with no unlock step in front of it
  task wr(input logic [7:0] d);
    @(negedge clock_i);
    ctrl_wr_i = 1'b1;
    ctrl_wdata_i = d;
    @(negedge clock_i);
    ctrl_wr_i = 1'b0;
    @(negedge clock_i);
  endtask

  // unlock then data back to back, strobe held across both
  task prog(input logic [7:0] d);
    @(negedge clock_i);
    ctrl_wr_i = 1'b1;
    ctrl_wdata_i = 8'h01;
    @(negedge clock_i);
    ctrl_wdata_i = d;
    @(negedge clock_i);
    ctrl_wr_i = 1'b0;
    @(negedge clock_i);
  endtask

  // bounded wait for a pulse; irq selects which output is watched
  task wait_pulse(input bit irq, input int lo, input int hi);
    c = 0;
    while (c < 2000 && (irq ? wd_irq_o : wd_reset_o) !== 1'b1)
    begin
      @(negedge clock_i);
      c++;
    end
    // the window allows for the few cycles of the write itself;
    // a wait that ran out fails it here and then ends the run
    check(c >= lo && c <= hi, 1'b1);
    if (c >= 2000)
      end_of_test();
  endtask

  // main sequence, inputs change only at falling edges
  initial
  begin
    repeat (6) @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clock_i);
    check(status_o, 8'h90);
    wr(8'h0a);
    check(status_o, 8'h90);
    // a lone unlock opens the window; it is still open on its last cycle
    // and a plain word one cycle later is dropped
    wr(8'h01);
    check(status_o, 8'h91);
    repeat (7) @(negedge clock_i);
    check(status_o, 8'h91);
    wr(8'h0a);
    check(status_o, 8'h90);
    prog(8'h0a);
    check(status_o, 8'h0a);
    wait_pulse(1'b1, 394, 402);
    @(negedge clock_i);
    check(status_o, 8'h0e);
    prog(8'h0a);
    check(status_o, 8'h0a);
    repeat (300) @(negedge clock_i);
    // no timeout yet, three quarters into the period
    check(status_o, 8'h0a);
    prog(8'h1a);
    wait_pulse(1'b1, 794, 802);
    @(negedge clock_i);
    supply_monitor_irq_i = 1'b1;
    @(negedge clock_i);
    supply_monitor_irq_i = 1'b0;
    @(negedge clock_i);
    check(status_o, 8'h1c);
    prog(8'h02);
    wait_pulse(1'b0, 394, 402);
    repeat (2) @(negedge clock_i);
    check(status_o, 8'h04);
    rstn_i = 1'b0;
    @(negedge clock_i);
    rstn_i = 1'b1;
    repeat (3) @(negedge clock_i);
    check(status_o, 8'h90);
    end_of_test();
  end
endmodule // tb_top
`default_nettype wire
